// File: shared/lasm_pkg.sv
// constants shared by the limit alert status and mask block
// Function
// - status two bit 7 sets on an open or short of diode pair two
// - status two bit 6 sets on an open or short of diode pair one
// - status two bit 5: fan four slow, thermal timer over, or input six
// - status two bits 4, 3, 2 set for slow fans three, two, one
// - status two bit 1 sets while overtemperature limit is exceeded
// - status two bit 0: high rail window fault, or code change when selected
// - out-of-limit bits set on fault; clear only after fault gone and read
// - alert stays low while unmasked fault persists and, for latched bits, until status is read
// - overtemperature bit does not latch; it follows the condition
// - mask bits block only the alert, status bits still set
// - mask one bit 7 blocks alert for everything in status two
// - mask one bits 6..0 block alert for each status one channel
// - mask two bits 7 and 6 block alert for diode two and one faults
// - mask two bit 5 blocks fan four, thermal or input six events
// - mask two bits 4, 3, 2 block alert for fans three, two, one
// - mask two bit 1 blocks overtemperature, bit 0 high rail or code change
// - alert output off after reset; driven only when a pin selects it
// - status one bit 7 reads 1 while any status two bit is set
// - status one bits 6..0 flag channel violations 6..0, bit 0 the thermal limit pin instead when selected
// - high fault when reading above limit, low fault when at or below
package lasm_pkg;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned NUM_CHAN = 8;
  localparam int unsigned NUM_FAN = 4;
  localparam int unsigned VID_W = 5;

  localparam logic [7:0] ADDR_STATUS_ONE = 8'h41;
  localparam logic [7:0] ADDR_STATUS_TWO = 8'h42;
  localparam logic [7:0] ADDR_MASK_ONE = 8'h74;
  localparam logic [7:0] ADDR_MASK_TWO = 8'h75;

  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;

  // status / mask field positions
  localparam int unsigned BIT_SUMMARY = 7;
  localparam int unsigned BIT_DIODE_TWO = 7;
  localparam int unsigned BIT_DIODE_ONE = 6;
  localparam int unsigned BIT_FAN_FOUR = 5;
  localparam int unsigned BIT_FAN_THREE = 4;
  localparam int unsigned BIT_FAN_TWO = 3;
  localparam int unsigned BIT_FAN_ONE = 2;
  localparam int unsigned BIT_OVERTEMP = 1;
  localparam int unsigned BIT_HIGH_RAIL = 0;
  localparam int unsigned CHAN_HIGH_RAIL = 7;
  localparam int unsigned CHAN_LOW_RAIL = 0;

  // shared pin function codes
  typedef enum logic [1:0] {
    LASM_PIN_FAN_SPEED = 2'h0,
    LASM_PIN_THERMAL   = 2'h1,
    LASM_PIN_ALERT     = 2'h2,
    LASM_PIN_GENERAL   = 2'h3
  } lasm_pin_func_e;
endpackage

// File: hdl/lasm_sticky_bits.sv
// bank of status bits, each sticky or plain follower
`timescale 1ns/1ps
module lasm_sticky_bits
  import lasm_pkg::*;
#(
  parameter int unsigned WIDTH = 8
)
(
  input  wire logic             clk,
  input  wire logic             resetn,
  input  wire logic [WIDTH-1:0] cond,
  input  wire logic [WIDTH-1:0] sticky,
  input  wire logic             read_clear,
  output logic      [WIDTH-1:0] status_q
);
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_bit
      logic status_d;
      // set wins over the read clear; a live fault survives the read
      always_comb
      begin
        status_d = cond[i] | (sticky[i] & status_q[i] & ~read_clear);
      end
      always_ff @(posedge clk)
      begin
        if (!resetn)
        begin
          status_q[i] <= 1'b0;
        end
        else
        begin
          status_q[i] <= status_d;
        end
      end
    end
  endgenerate
endmodule

// File: hdl/lasm_top.sv
// limit alert status capture, mask registers and alert pin drive
`timescale 1ns/1ps
module lasm_top
  import lasm_pkg::*;
#(
  parameter int unsigned NCH = lasm_pkg::NUM_CHAN
)
(
  input  wire logic                      CLK_SYS,
  input  wire logic                      RESETN,
  input  wire logic [7:0]                REG_ADDR,
  input  wire logic                      REG_WR,
  input  wire logic                      REG_RD,
  input  wire logic [lasm_pkg::DATA_W-1:0] REG_WDATA,
  output logic      [lasm_pkg::DATA_W-1:0] REG_RDATA,
  input  wire logic [NCH-1:0]            CHAN_DONE,
  input  wire logic [NCH*8-1:0]          CHAN_READING,
  input  wire logic [NCH*8-1:0]          CHAN_HIGH_LIMIT,
  input  wire logic [NCH*8-1:0]          CHAN_LOW_LIMIT,
  input  wire logic                      THERMAL_LIMIT_PIN_SEL,
  input  wire logic                      THERMAL_LIMIT_PIN_ASSERTED,
  input  wire logic                      DIODE_TWO_FAULT,
  input  wire logic                      DIODE_ONE_FAULT,
  input  wire logic [lasm_pkg::NUM_FAN-1:0] FAN_BELOW_MIN,
  input  wire logic                      THERMAL_LIMIT_PIN_TIMER_OVER,
  input  wire logic                      GENERAL_INPUT_SIX,
  input  wire logic                      OVERTEMP,
  input  wire logic [lasm_pkg::VID_W-1:0] VOLTAGE_ID_INPUTS,
  input  wire logic                      CODE_CHANGE_SEL,
  input  wire logic [1:0]                PIN14_FUNC,
  input  wire logic                      PIN10_ALERT_SEL,
  output logic                           PIN10_ALERT_O,
  output logic                           PIN10_ALERT_OE,
  output logic                           PIN14_ALERT_O,
  output logic                           PIN14_ALERT_OE
);
  import lasm_pkg::*;

  function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] off);
    addr_hit = (addr == off);
  endfunction

  logic [NCH-1:0]         win_fault_q;
  logic [VID_W-1:0]       vid_q;
  logic                   vid_valid_q;
  logic                   vid_change;
  logic [DATA_W-1:0]      mask_one_q;
  logic [DATA_W-1:0]      mask_two_q;
  logic [DATA_W-2:0]      cond_one;
  logic [DATA_W-1:0]      cond_two;
  logic [DATA_W-1:0]      sticky_two;
  logic [DATA_W-2:0]      status_one_q;
  logic [DATA_W-1:0]      status_two_q;
  logic                   second_register_summary;
  logic                   rd_status_one;
  logic                   rd_status_two;
  logic                   alert_d;
  logic                   alert_q;
  logic                   pin14_alert_en;
  logic                   fan_four_or_thermal_cond;
  logic [DATA_W-1:0]      rdata_d;

  // window comparators, result held from the last measurement of each channel
  genvar c;
  generate
    for (c = 0; c < NCH; c++)
    begin : g_win
      logic [7:0] rd_v;
      logic [7:0] hi_v;
      logic [7:0] lo_v;
      assign rd_v = CHAN_READING[c*8 +: 8];
      assign hi_v = CHAN_HIGH_LIMIT[c*8 +: 8];
      assign lo_v = CHAN_LOW_LIMIT[c*8 +: 8];
      always_ff @(posedge CLK_SYS)
      begin
        if (!RESETN)
        begin
          win_fault_q[c] <= 1'b0;
        end
        else if (CHAN_DONE[c])
        begin
          win_fault_q[c] <= (rd_v > hi_v) || (rd_v <= lo_v);
        end
      end
    end
  endgenerate

  // code change detector; first sample after reset is only a reference
  always_ff @(posedge CLK_SYS)
  begin
    if (!RESETN)
    begin
      vid_q       <= '0;
      vid_valid_q <= 1'b0;
    end
    else
    begin
      vid_q       <= VOLTAGE_ID_INPUTS;
      vid_valid_q <= 1'b1;
    end
  end
  assign vid_change = vid_valid_q && (VOLTAGE_ID_INPUTS != vid_q);

  // status one conditions, channel index equals bit position
  always_comb
  begin
    cond_one = win_fault_q[DATA_W-2:0];
    if (THERMAL_LIMIT_PIN_SEL)
    begin
      cond_one[CHAN_LOW_RAIL] = THERMAL_LIMIT_PIN_ASSERTED;
    end
  end

  always_comb
  begin
    unique case (lasm_pin_func_e'(PIN14_FUNC))
      LASM_PIN_FAN_SPEED: fan_four_or_thermal_cond = FAN_BELOW_MIN[3];
      LASM_PIN_THERMAL:   fan_four_or_thermal_cond = THERMAL_LIMIT_PIN_TIMER_OVER;
      LASM_PIN_GENERAL:   fan_four_or_thermal_cond = GENERAL_INPUT_SIX;
      LASM_PIN_ALERT:     fan_four_or_thermal_cond = 1'b0;
    endcase
  end

  always_comb
  begin
    cond_two                = '0;
    cond_two[BIT_DIODE_TWO] = DIODE_TWO_FAULT;
    cond_two[BIT_DIODE_ONE] = DIODE_ONE_FAULT;
    cond_two[BIT_FAN_FOUR]  = fan_four_or_thermal_cond;
    cond_two[BIT_FAN_THREE] = FAN_BELOW_MIN[2];
    cond_two[BIT_FAN_TWO]   = FAN_BELOW_MIN[1];
    cond_two[BIT_FAN_ONE]   = FAN_BELOW_MIN[0];
    cond_two[BIT_OVERTEMP]  = OVERTEMP;
    cond_two[BIT_HIGH_RAIL] = CODE_CHANGE_SEL ? vid_change : win_fault_q[CHAN_HIGH_RAIL];
  end

  // overtemperature never latches; input six is mirrored, not captured
  always_comb
  begin
    sticky_two               = '1;
    sticky_two[BIT_OVERTEMP] = 1'b0;
    sticky_two[BIT_FAN_FOUR] = (lasm_pin_func_e'(PIN14_FUNC) != LASM_PIN_GENERAL);
  end

  assign rd_status_one = REG_RD && addr_hit(REG_ADDR, ADDR_STATUS_ONE);
  assign rd_status_two = REG_RD && addr_hit(REG_ADDR, ADDR_STATUS_TWO);

  lasm_sticky_bits #(
    .WIDTH (DATA_W-1)
  ) u_status_one (
    .clk        (CLK_SYS),
    .resetn     (RESETN),
    .cond       (cond_one),
    .sticky     ({(DATA_W-1){1'b1}}),
    .read_clear (rd_status_one),
    .status_q   (status_one_q)
  );

  lasm_sticky_bits #(
    .WIDTH (DATA_W)
  ) u_status_two (
    .clk        (CLK_SYS),
    .resetn     (RESETN),
    .cond       (cond_two),
    .sticky     (sticky_two),
    .read_clear (rd_status_two),
    .status_q   (status_two_q)
  );

  assign second_register_summary = |status_two_q;

  // mask registers, write only from the register port
  always_ff @(posedge CLK_SYS)
  begin
    if (!RESETN)
    begin
      mask_one_q <= MASK_RESET;
    end
    else if (REG_WR && addr_hit(REG_ADDR, ADDR_MASK_ONE))
    begin
      mask_one_q <= REG_WDATA;
    end
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (!RESETN)
    begin
      mask_two_q <= MASK_RESET;
    end
    else if (REG_WR && addr_hit(REG_ADDR, ADDR_MASK_TWO))
    begin
      mask_two_q <= REG_WDATA;
    end
  end

  // read data returns the value before the read clear takes effect
  always_comb
  begin
    rdata_d = READ_UNMAPPED;
    if (addr_hit(REG_ADDR, ADDR_STATUS_ONE))
    begin
      rdata_d = {second_register_summary, status_one_q};
    end
    else if (addr_hit(REG_ADDR, ADDR_STATUS_TWO))
    begin
      rdata_d = status_two_q;
    end
    else if (addr_hit(REG_ADDR, ADDR_MASK_ONE))
    begin
      rdata_d = mask_one_q;
    end
    else if (addr_hit(REG_ADDR, ADDR_MASK_TWO))
    begin
      rdata_d = mask_two_q;
    end
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (!RESETN)
    begin
      REG_RDATA <= READ_UNMAPPED;
    end
    else if (REG_RD)
    begin
      REG_RDATA <= rdata_d;
    end
  end

  // alert built from status bits, so it holds until read after the fault, except for overtemperature and input six
  always_comb
  begin
    alert_d = |(status_one_q & ~mask_one_q[DATA_W-2:0])
            | (~mask_one_q[BIT_SUMMARY] & |(status_two_q & ~mask_two_q));
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (!RESETN)
    begin
      alert_q <= 1'b0;
    end
    else
    begin
      alert_q <= alert_d;
    end
  end

  assign pin14_alert_en = (lasm_pin_func_e'(PIN14_FUNC) == LASM_PIN_ALERT);

  // open drain: enable only while pulling low, pins idle released after reset
  always_ff @(posedge CLK_SYS)
  begin
    if (!RESETN)
    begin
      PIN10_ALERT_O  <= 1'b1;
      PIN10_ALERT_OE <= 1'b0;
      PIN14_ALERT_O  <= 1'b1;
      PIN14_ALERT_OE <= 1'b0;
    end
    else
    begin
      PIN10_ALERT_O  <= ~(alert_q & PIN10_ALERT_SEL);
      PIN10_ALERT_OE <= alert_q & PIN10_ALERT_SEL;
      PIN14_ALERT_O  <= ~(alert_q & pin14_alert_en);
      PIN14_ALERT_OE <= alert_q & pin14_alert_en;
    end
  end

  AST_DIODE_TWO_SET:
    assert property (@(posedge CLK_SYS) disable iff (!RESETN)
      DIODE_TWO_FAULT |=> status_two_q[BIT_DIODE_TWO])
    else $error("diode two fault did not set its status bit");

  AST_STICKY_HOLD:
    assert property (@(posedge CLK_SYS) disable iff (!RESETN)
      $rose(status_two_q[BIT_FAN_ONE]) && !rd_status_two ##1 !rd_status_two
      |-> status_two_q[BIT_FAN_ONE])
    else $error("fan one status bit dropped without a read");

  AST_READ_KEEPS_LIVE:
    assert property (@(posedge CLK_SYS) disable iff (!RESETN)
      rd_status_two && FAN_BELOW_MIN[0] |=> status_two_q[BIT_FAN_ONE])
    else $error("read cleared a fan one fault still present");

  AST_READ_CLEARS_GONE:
    assert property (@(posedge CLK_SYS) disable iff (!RESETN)
      rd_status_two && !DIODE_ONE_FAULT |=> !status_two_q[BIT_DIODE_ONE])
    else $error("read left a diode one bit set after fault ended");

  AST_OVERTEMP_FOLLOWS:
    assert property (@(posedge CLK_SYS) disable iff (!RESETN)
      ##1 status_two_q[BIT_OVERTEMP] == $past(OVERTEMP))
    else $error("overtemperature bit did not follow the condition");

  AST_SUMMARY_READ:
    assert property (@(posedge CLK_SYS) disable iff (!RESETN)
      rd_status_one |=> REG_RDATA[BIT_SUMMARY] == $past(|status_two_q))
    else $error("summary bit does not reflect status two");

  AST_MASK_KEEPS_STATUS:
    assert property (@(posedge CLK_SYS) disable iff (!RESETN)
      mask_two_q[BIT_FAN_THREE] && FAN_BELOW_MIN[2] |=> status_two_q[BIT_FAN_THREE])
    else $error("masked fan three fault did not set status");

  AST_SUMMARY_MASK:
    assert property (@(posedge CLK_SYS) disable iff (!RESETN)
      mask_one_q[BIT_SUMMARY] && ((status_one_q & ~mask_one_q[DATA_W-2:0]) == '0)
      |=> !alert_q)
    else $error("alert raised although status two is masked");

  AST_ALERT_PIN:
    assert property (@(posedge CLK_SYS) disable iff (!RESETN)
      alert_d && PIN10_ALERT_SEL ##1 PIN10_ALERT_SEL |=> PIN10_ALERT_OE && !PIN10_ALERT_O)
    else $error("unmasked status did not pull the alert pin low");

  AST_PIN_DISABLED:
    assert property (@(posedge CLK_SYS) disable iff (!RESETN)
      !PIN10_ALERT_SEL |=> !PIN10_ALERT_OE)
    else $error("alert pin driven without being selected");

  AST_HIGH_COMPARE:
    assert property (@(posedge CLK_SYS) disable iff (!RESETN)
      CHAN_DONE[CHAN_HIGH_RAIL] && !CODE_CHANGE_SEL
      && (CHAN_READING[CHAN_HIGH_RAIL*8 +: 8] > CHAN_HIGH_LIMIT[CHAN_HIGH_RAIL*8 +: 8])
      ##1 !CODE_CHANGE_SEL |=> status_two_q[BIT_HIGH_RAIL])
    else $error("high rail reading above limit not flagged");
endmodule

// File: test/lasm_host_model.sv
// host side of the alert line: pull-up wire shared by both alert pins
`timescale 1ns/1ps
module lasm_host_model
(
  input  wire logic p10_o,
  input  wire logic p10_oe,
  input  wire logic p14_o,
  input  wire logic p14_oe,
  output logic      alert_n
);
  // released line floats up, any enabled low driver wins
  assign alert_n = !((p10_oe && !p10_o) || (p14_oe && !p14_o));
endmodule

// File: test/lasm_top_tb.sv
// self-checking bench for the limit alert status and mask block
`timescale 1ns/1ps
module lasm_top_tb;
  import lasm_pkg::*;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic        wr_s = 1'b0;
  logic        rd_s = 1'b0;
  logic [7:0]  wdata = 8'h00;
  logic [7:0]  rdata;
  logic [7:0]  done = 8'h00;
  logic [63:0] rdg = {8{8'h80}};
  logic [63:0] hi = {8{8'hc0}};
  logic [63:0] lo = {8{8'h40}};
  logic        d_two = 1'b0;
  logic        d_one = 1'b0;
  logic [3:0]  fan = 4'h0;
  logic        overtemperature_flag = 1'b0;
  logic [4:0]  vid = 5'h00;
  logic        code_sel = 1'b0;
  logic [1:0]  p14_func = 2'h0;
  logic        p10_sel = 1'b0;
  logic        thermal_limit_pin_sel = 1'b0;
  logic        thermal_limit_pin_as = 1'b0;
  logic        timer_over = 1'b0;
  logic        gpi6 = 1'b0;
  logic        p10_o;
  logic        p10_oe;
  logic        p14_o;
  logic        p14_oe;
  logic        alert_n;
  int          fails = 0;
  int          compares = 0;

  always #2.5 clk = ~clk;

  lasm_top #(.NCH(8)) lasm_top_inst (
    .CLK_SYS(clk), .RESETN(rstn), .REG_ADDR(addr), .REG_WR(wr_s), .REG_RD(rd_s),
    .REG_WDATA(wdata), .REG_RDATA(rdata), .CHAN_DONE(done), .CHAN_READING(rdg),
    .CHAN_HIGH_LIMIT(hi), .CHAN_LOW_LIMIT(lo), .THERMAL_LIMIT_PIN_SEL(thermal_limit_pin_sel), .THERMAL_LIMIT_PIN_ASSERTED(thermal_limit_pin_as),
    .DIODE_TWO_FAULT(d_two), .DIODE_ONE_FAULT(d_one), .FAN_BELOW_MIN(fan),
    .THERMAL_LIMIT_PIN_TIMER_OVER(timer_over), .GENERAL_INPUT_SIX(gpi6), .OVERTEMP(overtemperature_flag),
    .VOLTAGE_ID_INPUTS(vid), .CODE_CHANGE_SEL(code_sel), .PIN14_FUNC(p14_func),
    .PIN10_ALERT_SEL(p10_sel), .PIN10_ALERT_O(p10_o), .PIN10_ALERT_OE(p10_oe),
    .PIN14_ALERT_O(p14_o), .PIN14_ALERT_OE(p14_oe));

  lasm_host_model lasm_host_model_inst (
    .p10_o(p10_o), .p10_oe(p10_oe), .p14_o(p14_o), .p14_oe(p14_oe), .alert_n(alert_n));

  task automatic final_report;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk1(input string what, input logic exp, input logic got);
    compares++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr = a;
    wdata = d;
    wr_s = 1'b1;
    cyc(1);
    wr_s = 1'b0;
    // idle cycle so a following call never re-raises a strobe in the same step
    cyc(1);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    addr = a;
    rd_s = 1'b1;
    cyc(1);
    rd_s = 1'b0;
    chk8("read data", exp, rdata);
    cyc(1);
  endtask

  // pin lags the fault by three edges, four gives margin
  task automatic line(input logic exp);
    cyc(4);
    chk1("alert line", exp, alert_n);
  endtask

  task automatic src(input int i, input logic v);
    case (i)
      7: d_two = v;
      6: d_one = v;
      default: fan[i-2] = v;
    endcase
  endtask

  task automatic meas(input int c, input logic [7:0] v);
    rdg[c*8 +: 8] = v;
    done[c] = 1'b1;
    cyc(1);
    done[c] = 1'b0;
    cyc(1);
  endtask

  initial
  begin
    #100000;
    fails++;
    final_report;
  end

  initial
  begin
    logic [7:0] a;
    logic [7:0] e;
    cyc(2);
    rstn = 1'b1;
    d_two = 1'b1;
    line(1'b1);
    chk1("pin14 enable", 1'b0, p14_oe);
    p10_sel = 1'b1;
    line(1'b0);
    d_two = 1'b0;
    rd(ADDR_STATUS_TWO, 8'h80);
    rd(ADDR_STATUS_TWO, 8'h00);
    rd(ADDR_MASK_ONE, MASK_RESET);
    wr(ADDR_MASK_ONE, 8'ha5);
    wr(ADDR_MASK_TWO, 8'h5a);
    wr(ADDR_STATUS_TWO, 8'hff);
    rd(ADDR_MASK_ONE, 8'ha5);
    rd(ADDR_MASK_TWO, 8'h5a);
    rd(ADDR_STATUS_TWO, 8'h00);
    rd(8'h30, READ_UNMAPPED);
    wr(ADDR_MASK_ONE, 8'h00);
    wr(ADDR_MASK_TWO, 8'h00);
    $display("test registers done");
    for (int i = 2; i < 8; i++)
    begin
      src(i, 1'b1);
      line(1'b0);
      src(i, 1'b0);
      line(1'b0);
      rd(ADDR_STATUS_ONE, 8'h80);
      rd(ADDR_STATUS_TWO, 8'h01 << i);
      line(1'b1);
      rd(ADDR_STATUS_TWO, 8'h00);
      wr(ADDR_MASK_TWO, 8'h01 << i);
      src(i, 1'b1);
      line(1'b1);
      rd(ADDR_STATUS_TWO, 8'h01 << i);
      src(i, 1'b0);
      rd(ADDR_STATUS_TWO, 8'h01 << i);
      rd(ADDR_STATUS_TWO, 8'h00);
      wr(ADDR_MASK_TWO, 8'h00);
    end
    $display("test sticky sources done");
    wr(ADDR_MASK_ONE, 8'h80);
    overtemperature_flag = 1'b1;
    line(1'b1);
    rd(ADDR_STATUS_TWO, 8'h02);
    wr(ADDR_MASK_ONE, 8'h00);
    line(1'b0);
    overtemperature_flag = 1'b0;
    line(1'b1);
    rd(ADDR_STATUS_TWO, 8'h00);
    wr(ADDR_MASK_TWO, 8'h02);
    overtemperature_flag = 1'b1;
    line(1'b1);
    overtemperature_flag = 1'b0;
    wr(ADDR_MASK_TWO, 8'h00);
    p10_sel = 1'b0;
    p14_func = 2'h2;
    d_one = 1'b1;
    line(1'b0);
    chk1("pin10 enable", 1'b0, p10_oe);
    d_one = 1'b0;
    rd(ADDR_STATUS_TWO, 8'h40);
    rd(ADDR_STATUS_TWO, 8'h00);
    p14_func = 2'h0;
    p10_sel = 1'b1;
    $display("test overtemp and pins done");
    for (int c = 0; c < 8; c++)
    begin
      a = (c == 7) ? ADDR_STATUS_TWO : ADDR_STATUS_ONE;
      e = (c == 7) ? 8'h01 : 8'h01 << c;
      meas(c, 8'hc1);
      rd(a, e);
      meas(c, 8'hc0);
      rd(a, e);
      rd(a, 8'h00);
    end
    meas(5, 8'h41);
    rd(ADDR_STATUS_ONE, 8'h00);
    wr(ADDR_MASK_ONE, 8'h20);
    meas(5, 8'h40);
    line(1'b1);
    rd(ADDR_STATUS_ONE, 8'h20);
    wr(ADDR_MASK_ONE, 8'h00);
    line(1'b0);
    meas(5, 8'h80);
    rd(ADDR_STATUS_ONE, 8'h20);
    rd(ADDR_STATUS_ONE, 8'h00);
    line(1'b1);
    code_sel = 1'b1;
    vid = 5'h01;
    cyc(3);
    rd(ADDR_STATUS_TWO, 8'h01);
    rd(ADDR_STATUS_TWO, 8'h00);
    $display("test channels done");
    code_sel = 1'b0;
    p14_func = 2'h1;
    timer_over = 1'b1;
    cyc(2);
    rd(ADDR_STATUS_TWO, 8'h20);
    timer_over = 1'b0;
    rd(ADDR_STATUS_TWO, 8'h20);
    rd(ADDR_STATUS_TWO, 8'h00);
    p14_func = 2'h3;
    gpi6 = 1'b1;
    cyc(2);
    rd(ADDR_STATUS_TWO, 8'h20);
    // input six is mirrored, so it drops without a read
    gpi6 = 1'b0;
    cyc(2);
    rd(ADDR_STATUS_TWO, 8'h00);
    p14_func = 2'h0;
    thermal_limit_pin_sel = 1'b1;
    thermal_limit_pin_as = 1'b1;
    cyc(2);
    rd(ADDR_STATUS_ONE, 8'h01);
    thermal_limit_pin_as = 1'b0;
    rd(ADDR_STATUS_ONE, 8'h01);
    rd(ADDR_STATUS_ONE, 8'h00);
    $display("test shared pin modes done");
    final_report;
  end
endmodule
